/* logic/lcdc_top.sv */
`timescale 1ns/1ps
`include "lcdc_regs.svh"

module lcdc_top #(
  parameter int SEG_COUNT = 27,
  parameter int RAM_AW    = 5
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_n_i,
  // register port
  input  wire logic [7:0]           addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  // clock source and port 3 function select
  input  wire logic                 watch_timer_clock_i,
  input  wire logic [3:0]           port3_function_select_i,
  // display ram read port
  output logic      [RAM_AW-1:0]    ram_addr_o,
  output logic                      ram_rd_o,
  input  wire logic [7:0]           ram_data_i,
  // glass drive pattern
  output logic      [7:0]           common_line_o,
  output logic      [3:0]           common_alt_o,
  output logic      [SEG_COUNT-1:0] segment_o,
  output logic                      ac_phase_o,
  // bias network control
  output logic                      internal_divider_en_o,
  output logic                      external_bias_o,
  output logic                      divider_high_res_o,
  output logic      [1:0]           bias_o,
  // top bias rail ratio
  output logic                      contrast_enable_o,
  output logic      [3:0]           contrast_level_o,
  output logic      [4:0]           rail_num_o,
  output logic      [4:0]           rail_den_o
);

  // control registers
  logic [7:0] duty_clk_q;     // duty/bias and frame clock
  logic [7:0] display_on_bias_q;    // display, resistor, remap
  logic [7:0] contrast_q;     // contrast enable and level

  // decoded fields
  logic       display_on;           // display enable bit
  logic       bias_resistor_select; // external divider when set
  logic       common_line_remap;    // alternate common group
  logic [3:0] duty_bias_select;     // drive method code
  logic [1:0] frame_clock_select;   // step rate code
  logic       contrast_enable;      // rail trimming active
  logic [3:0] contrast_level;       // rail trim code
  logic [7:0] rd_mux;               // read data before the flop
  lcdc_pkg::lcdc_drive_t drive;     // decoded drive method
  logic       scan_run;             // display on with usable code
  logic [4:0] rail_num_d;           // rail numerator next
  logic [4:0] rail_den_d;           // rail denominator next
  logic [7:0] com_main_d;           // default group next
  logic [3:0] com_alt_d;            // alternate group next

  // link to the scan engine
  lcdc_scan_if #(.SEG_COUNT(SEG_COUNT), .RAM_AW(RAM_AW)) sif ();

  assign display_on           = display_on_bias_q[`LCDC_DISPLAY_ON_BIT];
  assign bias_resistor_select = display_on_bias_q[`LCDC_BIAS_RES_BIT];
  assign common_line_remap    = display_on_bias_q[`LCDC_COM_REMAP_BIT];
  assign duty_bias_select     = duty_clk_q[`LCDC_DBS_MSB:`LCDC_DBS_LSB];
  assign frame_clock_select   = duty_clk_q[`LCDC_FCLK_MSB:`LCDC_FCLK_LSB];
  assign contrast_enable      = contrast_q[`LCDC_CT_EN_BIT];
  assign contrast_level       = contrast_q[`LCDC_LEVEL_MSB:`LCDC_LEVEL_LSB];

  // register writes; reserved bits are masked off at the door
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_clk_q  <= `LCDC_RST_DUTY_CLK;
      display_on_bias_q <= `LCDC_RST_DISPLAY_ON_BIAS;
      contrast_q  <= `LCDC_RST_CONTRAST;
    end else if (wr_i) begin
      case (addr_i)
        `LCDC_ADDR_DUTY_CLK: begin
          duty_clk_q <= wdata_i & `LCDC_MASK_DUTY_CLK;
        end
        `LCDC_ADDR_DISPLAY_ON_BIAS: begin
          display_on_bias_q <= wdata_i & `LCDC_MASK_DISPLAY_ON_BIAS;
        end
        `LCDC_ADDR_CONTRAST: begin
          contrast_q <= wdata_i & `LCDC_MASK_CONTRAST;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end
  end

  // read selection; unmapped addresses read zero
  always_comb begin
    case (addr_i)
      `LCDC_ADDR_DUTY_CLK:  rd_mux = duty_clk_q;
      `LCDC_ADDR_DISPLAY_ON_BIAS: rd_mux = display_on_bias_q;
      `LCDC_ADDR_CONTRAST:  rd_mux = contrast_q;
      default:              rd_mux = 8'h00;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // drive method; an unusable code keeps the glass dark
  assign drive    = lcdc_pkg::lcdc_decode(duty_bias_select);
  assign scan_run = display_on & drive.valid;

  // the watch timer must be running or no step ever comes
  lcdc_frame_div u_div (
    .mclk_i               (mclk_i),
    .rst_n_i              (rst_n_i),
    .run_i                (scan_run),
    .frame_clock_select_i (frame_clock_select),
    .watch_timer_clock_i  (watch_timer_clock_i),
    .step_o               (sif.step)
  );

  assign sif.enable   = scan_run;
  assign sif.ncom     = drive.ncom;
  assign sif.ram_data = ram_data_i;
  assign ram_addr_o   = sif.ram_addr;
  assign ram_rd_o     = sif.ram_rd;

  // common scan and display ram fetch
  lcdc_scan #(.SEG_COUNT(SEG_COUNT), .RAM_AW(RAM_AW)) u_scan (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .sif     (sif)
  );

  // common routing: the alternate group only exists for commons 0-3,
  // so wider duties leave commons 4-7 on the default group
  generate
    for (genvar k = 0; k < 8; k++) begin : g_com
      if (k < 4) begin : g_remap
        // port 3 bit (3-k) carries common k in the alternate group
        logic alt_sel;
        assign alt_sel = common_line_remap &
                         port3_function_select_i[3-k];
        assign com_main_d[k] = alt_sel ? 1'b0 : sif.com_sel[k];
        assign com_alt_d[k]  = alt_sel ? sif.com_sel[k] : 1'b0;
      end else begin : g_fixed
        assign com_main_d[k] = sif.com_sel[k];
      end
    end
  endgenerate

  // pattern outputs, one flop stage after routing
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      common_line_o <= 8'h00;
      common_alt_o  <= 4'h0;
      segment_o     <= '0;
      ac_phase_o    <= 1'b0;
    end else begin
      common_line_o <= com_main_d;
      common_alt_o  <= com_alt_d;
      segment_o     <= sif.seg;
      ac_phase_o    <= sif.ac_phase;
    end
  end

  // bias network: nothing draws current while the display is off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      internal_divider_en_o <= 1'b0;
      external_bias_o       <= 1'b0;
      divider_high_res_o    <= 1'b0;
      bias_o                <= 2'h0;
    end else begin
      internal_divider_en_o <= scan_run & ~bias_resistor_select;
      external_bias_o       <= scan_run & bias_resistor_select;
      divider_high_res_o    <= scan_run & drive.res_hi;
      bias_o                <= drive.bias;
    end
  end

  // top rail ratio num/(base-code); base and num follow the bias
  always_comb begin
    case (drive.bias)
      lcdc_pkg::LCDC_BIAS_THIRD: begin
        rail_num_d = `LCDC_RAIL_NUM_THIRD;
        rail_den_d = `LCDC_RAIL_BASE_THIRD - {1'b0, contrast_level};
      end
      lcdc_pkg::LCDC_BIAS_HALF: begin
        rail_num_d = `LCDC_RAIL_NUM_HALF;
        rail_den_d = `LCDC_RAIL_BASE_HALF - {1'b0, contrast_level};
      end
      default: begin
        rail_num_d = `LCDC_RAIL_NUM_QTR;
        rail_den_d = `LCDC_RAIL_BASE_QTR - {1'b0, contrast_level};
      end
    endcase
    // without contrast control the rail sits at full supply
    if (!contrast_enable) begin
      rail_den_d = rail_num_d;
    end
  end

  // contrast outputs
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      contrast_enable_o <= 1'b0;
      contrast_level_o  <= 4'h0;
      rail_num_o        <= `LCDC_RAIL_NUM_QTR;
      rail_den_o        <= `LCDC_RAIL_NUM_QTR;
    end else begin
      contrast_enable_o <= contrast_enable;
      contrast_level_o  <= contrast_level;
      rail_num_o        <= rail_num_d;
      rail_den_o        <= rail_den_d;
    end
  end
endmodule

/* include/lcdc_regs.svh */
`ifndef LCDC_REGS_SVH
`define LCDC_REGS_SVH

// register byte addresses on the control port
`define LCDC_ADDR_DUTY_CLK   8'h99
`define LCDC_ADDR_DISPLAY_ON_BIAS  8'h9a
`define LCDC_ADDR_CONTRAST   8'h9b

// reset values, all three registers clear
`define LCDC_RST_DUTY_CLK    8'h00
`define LCDC_RST_DISPLAY_ON_BIAS   8'h00
`define LCDC_RST_CONTRAST    8'h00

// writable-bit masks, reserved bits read as zero
`define LCDC_MASK_DUTY_CLK   8'h3f
`define LCDC_MASK_DISPLAY_ON_BIAS  8'h13
`define LCDC_MASK_CONTRAST   8'h8f

// field positions, display/bias register
`define LCDC_DISPLAY_ON_BIT  0
`define LCDC_BIAS_RES_BIT    1
`define LCDC_COM_REMAP_BIT   4

// field positions, duty/clock register
`define LCDC_FCLK_LSB        0
`define LCDC_FCLK_MSB        1
`define LCDC_DBS_LSB         2
`define LCDC_DBS_MSB         5

// field positions, contrast register
`define LCDC_LEVEL_LSB       0
`define LCDC_LEVEL_MSB       3
`define LCDC_CT_EN_BIT       7

// timing: watch timer rate and slowest frame clock, in Hz
`define LCDC_WCK_HZ          32768
`define LCDC_FRAME_HZ_MIN    128

// top rail ratio, numerator and base of denominator per bias
`define LCDC_RAIL_NUM_QTR    5'd16
`define LCDC_RAIL_BASE_QTR   5'd31
`define LCDC_RAIL_NUM_THIRD  5'd12
`define LCDC_RAIL_BASE_THIRD 5'd27
`define LCDC_RAIL_NUM_HALF   5'd8
`define LCDC_RAIL_BASE_HALF  5'd23

`endif

/* include/lcdc_pkg.sv */
package lcdc_pkg;

  // bias ratio applied to the glass
  typedef enum logic [1:0] {
    LCDC_BIAS_HALF,
    LCDC_BIAS_THIRD,
    LCDC_BIAS_QUARTER
  } lcdc_bias_t;

  // decoded drive method
  typedef struct packed {
    logic       valid;   // code is one of the nine usable ones
    logic [3:0] ncom;    // number of commons scanned
    lcdc_bias_t bias;    // bias ratio
    logic       res_hi;  // 120k divider instead of 60k
  } lcdc_drive_t;

  // duty/bias code to drive method; unusable codes give valid = 0
  function automatic lcdc_drive_t lcdc_decode(input logic [3:0] code);
    lcdc_drive_t d;
    d = '{1'b1, 4'h8, LCDC_BIAS_QUARTER, 1'b0};
    case (code)
      4'h0: d = '{1'b1, 4'h8, LCDC_BIAS_QUARTER, 1'b0};
      4'h1: d = '{1'b1, 4'h6, LCDC_BIAS_QUARTER, 1'b0};
      4'h2: d = '{1'b1, 4'h5, LCDC_BIAS_THIRD, 1'b0};
      4'h3: d = '{1'b1, 4'h4, LCDC_BIAS_THIRD, 1'b0};
      4'h4: d = '{1'b1, 4'h3, LCDC_BIAS_THIRD, 1'b0};
      4'h5: d = '{1'b1, 4'h3, LCDC_BIAS_HALF, 1'b0};
      4'h6: d = '{1'b1, 4'h3, LCDC_BIAS_HALF, 1'b1};
      4'h7: d = '{1'b1, 4'h2, LCDC_BIAS_HALF, 1'b0};
      4'h8: d = '{1'b1, 4'h2, LCDC_BIAS_HALF, 1'b1};
      default: d = '{1'b0, 4'h2, LCDC_BIAS_HALF, 1'b0};
    endcase
    return d;
  endfunction

endpackage

/* include/lcdc_scan_if.sv */
`timescale 1ns/1ps
// control side to scan engine: steps, config, ram port, pattern
interface lcdc_scan_if #(
  parameter int SEG_COUNT = 27,
  parameter int RAM_AW    = 5
);
  logic                 step;      // one common step, one-cycle pulse
  logic                 enable;    // display on with a usable duty
  logic [3:0]           ncom;      // commons in the frame
  logic [7:0]           ram_data;  // display byte, cycle after read
  logic [RAM_AW-1:0]    ram_addr;  // display byte address
  logic                 ram_rd;    // read strobe
  logic [7:0]           com_sel;   // one-hot selected common
  logic [SEG_COUNT-1:0] seg;       // segment pattern for that common
  logic                 ac_phase;  // frame polarity for ac drive

  modport ctrl (
    output step, enable, ncom, ram_data,
    input  ram_addr, ram_rd, com_sel, seg, ac_phase
  );
  modport scan (
    input  step, enable, ncom, ram_data,
    output ram_addr, ram_rd, com_sel, seg, ac_phase
  );
endinterface

/* logic/lcdc_frame_div.sv */
`timescale 1ns/1ps
`include "lcdc_regs.svh"
// divides the watch timer clock down to the common step rate
module lcdc_frame_div (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // control
  input  wire logic       run_i,
  input  wire logic [1:0] frame_clock_select_i,
  input  wire logic       watch_timer_clock_i,
  // step pulse at the frame clock rate
  output logic            step_o
);
  // watch ticks per step at the slowest rate
  localparam int DIV_MAX = `LCDC_WCK_HZ / `LCDC_FRAME_HZ_MIN;
  localparam int CW      = $clog2(DIV_MAX);

  logic          wck_q;    // last watch clock level
  logic          wck_rise; // watch clock rising edge
  logic [CW-1:0] cnt_q;    // watch edges in this step
  logic [CW-1:0] last;     // terminal count for chosen rate

  // each select step doubles the rate, so halve the count
  assign last     = CW'((DIV_MAX >> frame_clock_select_i) - 1);
  assign wck_rise = watch_timer_clock_i & ~wck_q;

  // edge detect on the watch clock, never on mclk itself
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wck_q <= 1'b0;
    end else begin
      wck_q <= watch_timer_clock_i;
    end
  end

  // step counter; restarts when stopped so a new frame starts clean
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= '0;
      step_o <= 1'b0;
    end else if (!run_i) begin
      cnt_q  <= '0;
      step_o <= 1'b0;
    end else begin
      step_o <= 1'b0;
      if (wck_rise) begin
        if (cnt_q >= last) begin
          cnt_q  <= '0;
          step_o <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule

/* logic/lcdc_scan.sv */
`timescale 1ns/1ps
// steps through the commons and fetches each pattern from display ram
module lcdc_scan #(
  parameter int SEG_COUNT = 27,
  parameter int RAM_AW    = 5
) (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  // link to control side
  lcdc_scan_if.scan sif
);
  typedef enum logic [1:0] {SC_IDLE, SC_READ, SC_DRAIN} lcdc_scan_st_t;

  lcdc_scan_st_t        st_q;      // fetch state
  logic [2:0]           com_q;     // common being fetched
  logic [SEG_COUNT-1:0] shadow_q;  // pattern under collection
  logic                 cap_q;     // ram data valid this cycle
  logic [RAM_AW-1:0]    cap_addr_q;// address of that data
  logic [2:0]           next_com;  // following common, wrapped

  assign next_com = ({1'b0, com_q} + 4'h1 >= sif.ncom) ?
                    3'h0 : 3'(com_q + 3'h1);

  // fetch sequencer: one byte read per cycle over the whole area
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q         <= SC_IDLE;
      com_q        <= 3'h0;
      sif.ram_addr <= '0;
      sif.ram_rd   <= 1'b0;
      sif.ac_phase <= 1'b0;
    end else if (!sif.enable) begin
      // scanning suspended while dark
      st_q         <= SC_IDLE;
      com_q        <= 3'h0;
      sif.ram_addr <= '0;
      sif.ram_rd   <= 1'b0;
      sif.ac_phase <= 1'b0;
    end else begin
      case (st_q)
        SC_IDLE: begin
          if (sif.step) begin
            com_q        <= next_com;
            // flip polarity at each frame start to keep dc off the glass
            if (next_com == 3'h0) begin
              sif.ac_phase <= ~sif.ac_phase;
            end
            sif.ram_addr <= '0;
            sif.ram_rd   <= 1'b1;
            st_q         <= SC_READ;
          end
        end
        SC_READ: begin
          if (sif.ram_addr == RAM_AW'(SEG_COUNT - 1)) begin
            sif.ram_rd <= 1'b0;
            st_q       <= SC_DRAIN;
          end else begin
            sif.ram_addr <= sif.ram_addr + 1'b1;
          end
        end
        SC_DRAIN: begin
          if (!cap_q) begin
            st_q <= SC_IDLE;
          end
        end
        default: st_q <= SC_IDLE;
      endcase
    end
  end

  // capture: bit n of each byte belongs to common n
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_q      <= 1'b0;
      cap_addr_q <= '0;
      shadow_q   <= '0;
    end else begin
      cap_q      <= sif.ram_rd & sif.enable;
      cap_addr_q <= sif.ram_addr;
      if (cap_q) begin
        shadow_q[cap_addr_q] <= sif.ram_data[com_q];
      end
    end
  end

  // publish a full pattern at once so no half-fetched frame shows
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sif.seg     <= '0;
      sif.com_sel <= 8'h00;
    end else if (!sif.enable) begin
      sif.seg     <= '0;
      sif.com_sel <= 8'h00;
    end else if (st_q == SC_DRAIN && !cap_q) begin
      sif.seg     <= shadow_q;
      sif.com_sel <= 8'h01 << com_q;
    end
  end
endmodule

/* verification/lcdc_ram_model.sv */
`timescale 1ns/1ps
// display data ram: answers a fetch in the cycle after the strobe
module lcdc_ram_model #(
  parameter int RAM_AW = 5
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // fetch port
  input  wire logic              rd_i,
  input  wire logic [RAM_AW-1:0] addr_i,
  input  wire logic [7:0]        salt_i,
  output logic      [7:0]        data_o
);
  // byte a: bit n lights segment a on common n; salt varies the pattern
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      data_o <= 8'h00;
    else if (rd_i)
      data_o <= 8'(addr_i) * 8'h1d ^ salt_i;
    else
      data_o <= ~data_o;  // released bus flips so stale data never passes
  end
endmodule

/* verification/lcdc_top_sva.sv */
`timescale 1ns/1ps
// watches register port, display fetches and glass outputs
module lcdc_top_chk #(
  parameter int SEG_COUNT = 27,
  parameter int RAM_AW    = 5
) (
  // clock, reset, register port
  input wire logic                 mclk_i,
  input wire logic                 rst_n_i,
  input wire logic [7:0]           addr_i,
  input wire logic [7:0]           wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [7:0]           rdata_o,
  // port select and display ram
  input wire logic [3:0]           port3_function_select_i,
  input wire logic [RAM_AW-1:0]    ram_addr_o,
  input wire logic                 ram_rd_o,
  // glass, bias and rail
  input wire logic [7:0]           common_line_o,
  input wire logic [3:0]           common_alt_o,
  input wire logic [SEG_COUNT-1:0] segment_o,
  input wire logic                 internal_divider_en_o,
  input wire logic                 external_bias_o,
  input wire logic [1:0]           bias_o,
  input wire logic                 contrast_enable_o,
  input wire logic [3:0]           contrast_level_o,
  input wire logic [4:0]           rail_num_o,
  input wire logic [4:0]           rail_den_o
);
  logic [7:0] display_on_q;    // last byte written to the display/bias register
  logic [3:0] psel_rev;  // select bit per alternate common, k from 3-k
  logic [4:0] num_w;     // rail numerator for the current third or half bias
  logic [4:0] den_w;     // rail denominator base for the current third or half bias

  // shadow of the display/bias register, for gating checks
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      display_on_q <= 8'h00;
    else if (wr_i && addr_i == 8'h9a)
      display_on_q <= wdata_i;
  end
  assign psel_rev = {<<{port3_function_select_i}};
  assign num_w = (bias_o == 2'd1) ? 5'd12 : 5'd8;
  assign den_w = (bias_o == 2'd1) ? 5'd27 : 5'd23;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  chk_rd_idle_zero: assert property (
    !rd_i |=> rdata_o == 8'h00) else $error("read data not zero");
  chk_contrast_back: assert property (
    wr_i && addr_i == 8'h9b ##2 rd_i && addr_i == 8'h9b
    |=> rdata_o == ($past(wdata_i, 3) & 8'h8f))
    else $error("contrast readback wrong");
  chk_rail_quarter: assert property (
    (contrast_enable_o && bias_o == 2'd2 && $stable(contrast_level_o)
     && $stable(bias_o))[*3]
    |-> rail_num_o == 5'd16 && rail_den_o == 5'd31 - 5'(contrast_level_o))
    else $error("quarter rail wrong");
  chk_rail_scaled: assert property (
    (contrast_enable_o && bias_o != 2'd2 && $stable(contrast_level_o)
     && $stable(bias_o))[*3]
    |-> rail_num_o == num_w && rail_den_o == den_w - 5'(contrast_level_o))
    else $error("scaled rail wrong");
  chk_bias_source: assert property (
    (external_bias_o || internal_divider_en_o) && $stable(display_on_q)
    |-> external_bias_o == display_on_q[1] && internal_divider_en_o != display_on_q[1])
    else $error("bias resistor source wrong");
  chk_off_blank: assert property (
    wr_i && addr_i == 8'h9a && !wdata_i[0] |-> ##3
    (common_line_o == 8'h00 && common_alt_o == 4'h0 && segment_o == '0
     && !ram_rd_o)[*4]) else $error("outputs live while off");
  chk_one_common: assert property (
    $onehot0({common_alt_o, common_line_o}))
    else $error("more than one common active");
  chk_fetch_seq: assert property (
    ram_rd_o && ram_addr_o < 26 |=>
    ram_rd_o && ram_addr_o == $past(ram_addr_o) + 1'b1)
    else $error("fetch not consecutive");
  chk_fetch_stop: assert property (
    ram_rd_o && ram_addr_o == 26 |=> !ram_rd_o)
    else $error("fetch runs past last byte");
  chk_remap_gate: assert property (
    ($stable(display_on_q) && common_alt_o != 4'h0)[*3]
    |-> display_on_q[4] && (common_alt_o & ~psel_rev) == 4'h0)
    else $error("alternate common without select");
endmodule

bind lcdc_top lcdc_top_chk #(.SEG_COUNT(SEG_COUNT), .RAM_AW(RAM_AW)) u_chk (
  .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .port3_function_select_i, .ram_addr_o, .ram_rd_o, .common_line_o,
  .common_alt_o, .segment_o, .internal_divider_en_o, .external_bias_o,
  .bias_o, .contrast_enable_o, .contrast_level_o, .rail_num_o, .rail_den_o);

/* verification/lcdc_tb_top.sv */
`timescale 1ns/1ps
// bench: register tasks, watch clock, display ram model, scenarios
module lcdc_top_tb_top;
  logic        mclk_i;
  logic        rst_n_i;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        wck;       // watch clock, eight mclk per period
  logic        wck_run;   // low stops the watch clock
  logic [1:0]  wck_div;
  logic [3:0]  psel;
  logic [4:0]  ram_addr;
  logic        ram_rd;
  logic [7:0]  ram_data;
  logic [7:0]  salt;      // varies the display pattern per duty code in t_scan
  logic [7:0]  com;
  logic [3:0]  alt;
  logic [26:0] seg;
  logic        acp;       // frame polarity
  logic        idiv;
  logic        ext;
  logic        hres;
  logic [1:0]  bias;
  logic [4:0]  rnum;
  logic [4:0]  rden;
  int          n_mismatch;
  int          checks_done;

  lcdc_top dut (
    .mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .watch_timer_clock_i(wck), .port3_function_select_i(psel),
    .ram_addr_o(ram_addr), .ram_rd_o(ram_rd), .ram_data_i(ram_data),
    .common_line_o(com), .common_alt_o(alt), .segment_o(seg),
    .ac_phase_o(acp), .internal_divider_en_o(idiv), .external_bias_o(ext),
    .divider_high_res_o(hres), .bias_o(bias), .contrast_enable_o(),
    .contrast_level_o(), .rail_num_o(rnum), .rail_den_o(rden));

  lcdc_ram_model u_ram (.mclk_i, .rst_n_i, .rd_i(ram_rd),
    .addr_i(ram_addr), .salt_i(salt), .data_o(ram_data));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // watch clock runs only while enabled; t_frame stops it for 600 cycles
  always @(posedge mclk_i) begin
    wck_div <= wck_div + 2'd1;
    if (wck_run && wck_div == 2'd3) wck <= ~wck;
  end

  task automatic cmp(input string nm, input logic [39:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // read data is taken in the one cycle after the strobe edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  // bounded wait for the next change of the common outputs
  task automatic wait_pub(output int cyc);
    logic [11:0] last;
    last = {alt, com};
    cyc = 0;
    while ({alt, com} === last) begin
      @(posedge mclk_i);
      #1 cyc++;
      if (cyc > 5000) begin
        cmp("publish wait", 40'h1, 40'h0);
        wrap_up();
      end
    end
  endtask

  function automatic int idx_of(input logic [11:0] v);
    idx_of = 0;
    for (int i = 0; i < 12; i++) if (v[i]) idx_of = (i < 8) ? i : i - 8;
  endfunction

  function automatic logic [26:0] seg_exp(input int n);
    logic [7:0] b;
    for (int a = 0; a < 27; a++) begin
      b = 8'(a) * 8'h1d ^ salt;
      seg_exp[a] = b[n];
    end
  endfunction

  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] ad [4] = '{8'h99, 8'h9a, 8'h9c, 8'h9b};
    logic [7:0] mk [4] = '{8'h3f, 8'h13, 8'h00, 8'h8f};
    for (int i = 0; i < 4; i++) reg_rd(ad[i], d);
    cmp("rail at reset", {rnum, rden}, {5'd16, 5'd16});
    for (int i = 0; i < 4; i++) begin
      reg_rd(ad[i], d);
      cmp("reset value", d, 8'h00);
    end
    for (int i = 0; i < 4; i++) reg_wr(ad[i], 8'hff);
    for (int i = 3; i >= 0; i--) begin
      reg_rd(ad[i], d);
      cmp("readback", d, mk[i]);
    end
    for (int i = 0; i < 4; i++) reg_wr(ad[i], 8'h00);
    $display("test regs done");
  endtask

  task automatic t_contrast;
    logic [7:0] cd [3] = '{8'h00, 8'h08, 8'h14};
    logic [4:0] nm [3] = '{5'd16, 5'd12, 5'd8};
    logic [4:0] bs [3] = '{5'd31, 5'd27, 5'd23};
    logic [4:0] e;
    for (int b = 0; b < 3; b++) begin
      reg_wr(8'h99, cd[b]);
      for (int l = 0; l < 17; l++) begin
        reg_wr(8'h9b, (l < 16) ? 8'h80 | 8'(l) : 8'h00);
        e = (l < 16) ? bs[b] - 5'(l) : nm[b];
        repeat (4) @(posedge mclk_i);
        #1 cmp("rail", {rnum, rden}, {nm[b], e});
        cmp("bias", bias, 2'd2 - 2'(b));
      end
    end
    $display("test contrast done");
  endtask

  task automatic t_scan;
    int nc [9] = '{8, 6, 5, 4, 3, 3, 3, 2, 2};
    int cyc;
    int prev;
    int cur;
    for (int c = 0; c < 10; c++) begin
      salt <= 8'(c * 37);
      reg_wr(8'h99, 8'(c << 2) | 8'h03);
      reg_wr(8'h9a, 8'h01);
      if (c == 9) begin
        repeat (600) @(posedge mclk_i);
        #1 cmp("unusable code", {alt, com, seg}, 40'h0);
      end else begin
        for (int k = 0; k <= nc[c]; k++) begin
          wait_pub(cyc);
          cur = idx_of({alt, com});
          if (k > 0) cmp("order", 40'(cur), 40'((prev + 1) % nc[c]));
          cmp("segments", seg, seg_exp(cur));
          prev = cur;
        end
        cmp("bias net", {hres, idiv, ext}, {c == 6 || c == 8, 2'b10});
      end
      reg_wr(8'h9a, 8'h00);
      repeat (4) @(posedge mclk_i);
      #1 cmp("display off", {alt, com, seg, idiv}, 40'h0);
    end
    $display("test scan done");
  endtask

  task automatic t_frame;
    int cyc;
    reg_wr(8'h9a, 8'h01);
    for (int s = 0; s < 4; s++) begin
      reg_wr(8'h99, 8'h0c | 8'(s));
      repeat (3) wait_pub(cyc);
      cmp("step interval", 40'(cyc), 40'(8 * (256 >> s)));
    end
    repeat (40) @(posedge mclk_i);
    wck_run <= 1'b0;
    cyc = 0;
    repeat (600) begin
      @(posedge mclk_i);
      if (ram_rd !== 1'b0) cyc++;
    end
    cmp("fetch without watch clock", 40'(cyc), 40'h0);
    wck_run <= 1'b1;
    reg_wr(8'h9a, 8'h00);
    $display("test frame done");
  endtask

  task automatic t_remap;
    int cyc;
    int cur;
    logic [11:0] e;
    @(posedge mclk_i);
    psel <= 4'b1010;
    reg_wr(8'h99, 8'h0f);
    reg_wr(8'h9a, 8'h13);
    for (int k = 0; k < 5; k++) begin
      wait_pub(cyc);
      cur = idx_of({alt, com});
      e = psel[3 - cur] ? 12'h100 << cur : 12'h001 << cur;
      cmp("common routing", {alt, com}, e);
      cmp("external bias", {idiv, ext}, 2'b01);
      cmp("ac phase", acp, 40'(k >= 3));
    end
    reg_wr(8'h9a, 8'h00);
    psel <= 4'h0;
    $display("test remap done");
  endtask

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    rst_n_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    wck = 1'b0;
    wck_run = 1'b1;
    wck_div = 2'd0;
    psel = 4'h0;
    salt = 8'h00;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_contrast();
    t_scan();
    t_frame();
    t_remap();
    wrap_up();
  end
endmodule
